// ==== logic/fic_core.sv ====
`timescale 1ns/1ps
// Contract
// - Keep power-on, watchdog and oscillator-fail reset-cause flag bits.
// - Flash-command and external-pin resets set no cause flag.
// - Flash command field writes accepted only after timed access sequence.
// - Five levels; power-fail fixed at 4, others programmable 0 to 3.
// - Each source has a fixed vector: power-fail 33h, watchdog 63h.
// - Flags set on condition regardless of enables; vector needs enables.
// - Pin 0/1 flags clear on vector in edge mode, follow pin in level.
// - Timer 0/1 overflow flags clear automatically on vectoring.
// - Each source needs its individual enable bit to request.
// - Global gate low blocks all sources except power-fail.
// - Power-fail vectors when its own enable set, ignoring global gate.
// - Sample and arbitrate only in final memory cycle of an instruction.
// - Hold service state until return instruction, then resume old flow.
// - Preemption only by strictly higher level than one being serviced.
// - Equal levels resolve by natural order; natural order never preempts.
// - Pin 0/1 request on low level, or high-then-low samples in edge mode.
// - Pins 2,4 rising edge, pins 3,5 falling edge; flag 1 means pending.
module fic_core
  import fic_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // Reset cause, one-cycle pulses from the reset generators
  input  wire logic       por_event_i,
  input  wire logic       wdt_reset_event_i,
  input  wire logic       osc_fail_event_i,
  input  wire logic       sw_clr_por_i,
  input  wire logic       sw_clr_wdt_rst_i,
  input  wire logic       sw_clr_osc_rst_i,
  // Flash command access
  input  wire logic       ta_write_i,
  input  wire logic [7:0] ta_data_i,
  input  wire logic       flash_cmd_wr_i,
  input  wire logic [3:0] flash_cmd_data_i,
  // Configuration
  input  wire logic [7:0] interrupt_enable_reg_i,
  input  wire logic [4:0] ext_irq_enable_reg_i,
  input  wire logic [6:0] prio_low_bits_reg_i,
  input  wire logic [6:0] prio_high_bits_reg_i,
  input  wire logic [4:0] ext_prio_low_bits_reg_i,
  input  wire logic [4:0] ext_prio_high_bits_reg_i,
  input  wire logic       supply_drop_irq_en_i,
  input  wire logic [1:0] pin_trigger_mode_bit_i,
  // Event sources
  input  wire logic       supply_low_i,
  input  wire logic [5:0] ext_pin_i,
  input  wire logic       timer0_ovf_i,
  input  wire logic       timer1_ovf_i,
  input  wire logic       timer2_overflow_flag_i,
  input  wire logic       timer2_capture_edge_flag_i,
  input  wire logic [1:0] serial0_flags_i,
  input  wire logic [1:0] serial1_flags_i,
  input  wire logic       watchdog_irq_flag_i,
  // Software flag writes: clear mask then set mask, per source
  input  wire logic [12:0] sw_flag_clr_i,
  input  wire logic [12:0] sw_flag_set_i,
  // CPU sequencer
  input  wire logic       last_mem_cycle_i,
  input  wire logic       return_from_service_instr_i,
  // Outputs
  output logic            vector_req_o,
  output logic [7:0]      vector_addr_o,
  output logic [12:0]     flags_o,
  output logic [2:0]      active_level_o,
  output logic            in_service_o,
  output logic [7:0]      watchdog_ctrl_reg_o,
  output logic [7:0]      power_ctrl_reg_o,
  output logic [3:0]      flash_cmd_reg_o,
  output logic            flash_cmd_strobe_o
);
  // ----------------------------------------------------------------------
  // Reset cause flags survive the system reset; software clears, and a power-on event also clears the oscillator flag
  // ----------------------------------------------------------------------
  logic por_flag, wdt_flag, osc_flag;
  logic next_por_flag, next_wdt_flag, next_osc_flag;

  // Events win over a same-cycle clear; no input exists for flash or pin
  always_comb
  begin
    next_por_flag = por_event_i | (por_flag & ~sw_clr_por_i);
    next_wdt_flag = wdt_reset_event_i | (wdt_flag & ~sw_clr_wdt_rst_i);
    next_osc_flag = osc_fail_event_i
                  | (osc_flag & ~sw_clr_osc_rst_i & ~por_event_i);
  end

  // Deliberately not reset by sys_rst_i, else the cause would be lost
  always_ff @(posedge mclk_i)
  begin
    por_flag <= next_por_flag;
    wdt_flag <= next_wdt_flag;
    osc_flag <= next_osc_flag;
  end

  // ----------------------------------------------------------------------
  // Timed access for the flash command field
  // ----------------------------------------------------------------------
  fic_ta_type  ta_state, next_ta_state;
  logic [1:0]  ta_cnt, next_ta_cnt;
  logic [3:0]  fcmd, next_fcmd;
  logic        fstb, next_fstb;

  always_comb
  begin
    next_ta_state = ta_state;
    next_ta_cnt   = (ta_cnt == TA_IDLE) ? TA_IDLE : ta_cnt - 2'h1;
    next_fcmd     = fcmd;
    next_fstb     = 1'b0;
    case (ta_state)
      FIC_TA_IDLE:
        if (ta_write_i && ta_data_i == TA_KEY1)
        begin
          next_ta_state = FIC_TA_HALF;
          next_ta_cnt   = 2'(TA_WINDOW_CYC);
        end
      FIC_TA_HALF:
        if (ta_write_i && ta_data_i == TA_KEY2)
        begin
          next_ta_state = FIC_TA_OPEN;
          next_ta_cnt   = 2'(TA_WINDOW_CYC);
        end
        else if (ta_write_i || ta_cnt == TA_IDLE)
          next_ta_state = FIC_TA_IDLE;
      FIC_TA_OPEN:
        if (flash_cmd_wr_i)
        begin
          next_fcmd     = flash_cmd_data_i;
          next_fstb     = 1'b1;
          next_ta_state = FIC_TA_IDLE;
        end
        else if (ta_cnt == TA_IDLE)
          next_ta_state = FIC_TA_IDLE;
      default:
        next_ta_state = FIC_TA_IDLE;
    endcase
  end // Writes while locked are silently dropped

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ta_state <= FIC_TA_IDLE;
      ta_cnt   <= TA_IDLE;
      fcmd     <= FLASH_CMD_RESET;
      fstb     <= 1'b0;
    end
    else
    begin
      ta_state <= next_ta_state;
      ta_cnt   <= next_ta_cnt;
      fcmd     <= next_fcmd;
      fstb     <= next_fstb;
    end
  end

  // ----------------------------------------------------------------------
  // Source flags
  // ----------------------------------------------------------------------
  logic [5:0]  pin_q, next_pin_q;
  logic [12:0] flag, next_flag;
  logic [12:0] ev;
  logic [12:0] hw_ack_clr;
  logic        take;
  logic [3:0]  win_idx;

  // Condition pulses; pin samples are one cycle apart
  always_comb
  begin
    next_pin_q = ext_pin_i;
    ev         = '0;
    ev[SRC_T0] = timer0_ovf_i;
    ev[SRC_T1] = timer1_ovf_i;
    ev[SRC_X0] = pin_q[0] & ~ext_pin_i[0];
    ev[SRC_X1] = pin_q[1] & ~ext_pin_i[1];
    ev[SRC_X2] = ~pin_q[2] & ext_pin_i[2];
    ev[SRC_X3] = pin_q[3] & ~ext_pin_i[3];
    ev[SRC_X4] = ~pin_q[4] & ext_pin_i[4];
    ev[SRC_X5] = pin_q[5] & ~ext_pin_i[5];
    ev[SRC_WD] = watchdog_irq_flag_i;
  end

  // Only timer 0/1 and pins 0/1 in edge mode clear when acknowledged
  always_comb
  begin
    hw_ack_clr = '0;
    if (take)
    begin
      if (win_idx == 4'(SRC_T0) || win_idx == 4'(SRC_T1))
        hw_ack_clr[win_idx] = 1'b1;
      if (win_idx == 4'(SRC_X0) && pin_trigger_mode_bit_i[0])
        hw_ack_clr[SRC_X0] = 1'b1;
      if (win_idx == 4'(SRC_X1) && pin_trigger_mode_bit_i[1])
        hw_ack_clr[SRC_X1] = 1'b1;
    end
  end // Others stay set for software, except serial, timer 2 and level-mode pins, which follow their inputs

  // Set wins over any clear; enables play no part here
  always_comb
  begin
    next_flag = (flag & ~sw_flag_clr_i & ~hw_ack_clr) | ev | sw_flag_set_i;
    next_flag[SRC_PF] = supply_low_i | sw_flag_set_i[SRC_PF]
                      | (flag[SRC_PF] & ~sw_flag_clr_i[SRC_PF]);
    next_flag[SRC_S0] = |serial0_flags_i;
    next_flag[SRC_S1] = |serial1_flags_i;
    next_flag[SRC_T2] = timer2_overflow_flag_i | timer2_capture_edge_flag_i;
    if (!pin_trigger_mode_bit_i[0])
      next_flag[SRC_X0] = ~ext_pin_i[0];
    if (!pin_trigger_mode_bit_i[1])
      next_flag[SRC_X1] = ~ext_pin_i[1];
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      pin_q <= 6'h3F;
      flag  <= '0;
    end
    else
    begin
      pin_q <= next_pin_q;
      flag  <= next_flag;
    end
  end

  // ----------------------------------------------------------------------
  // Enables, levels and arbitration
  // ----------------------------------------------------------------------
  logic [12:0] en, req;
  logic [38:0] lvl;
  logic        win_any;
  logic [2:0]  win_lvl;
  logic [7:0]  win_vec;

  // Enable bits line up with sources 1..12
  always_comb
  begin
    en[SRC_PF] = supply_drop_irq_en_i;
    en[7:1]    = interrupt_enable_reg_i[6:0]
               & {7{interrupt_enable_reg_i[GATE_BIT]}};
    en[12:8]   = ext_irq_enable_reg_i
               & {5{interrupt_enable_reg_i[GATE_BIT]}};
    req        = flag & en;
  end

  // One level per source from its high and low priority bits; power-fail fixed at 4
  generate
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : g_lvl
      if (g == SRC_PF)
      begin : g_pf
        assign lvl[3*g +: 3] = LEVEL_PF;
      end
      else if (g < SRC_X2)
      begin : g_base
        assign lvl[3*g +: 3] = {1'b0, prio_high_bits_reg_i[g-1],
                                prio_low_bits_reg_i[g-1]};
      end
      else
      begin : g_ext
        assign lvl[3*g +: 3] = {1'b0, ext_prio_high_bits_reg_i[g-8],
                                ext_prio_low_bits_reg_i[g-8]};
      end
    end
  endgenerate

  fic_arbiter #(.N(NUM_SRC)) u_arb (
    .req_i   (req),
    .level_i (lvl),
    .any_o   (win_any),
    .idx_o   (win_idx),
    .level_o (win_lvl)
  );

  // Fixed vector table
  always_comb
  begin
    case (win_idx)
      4'(SRC_PF): win_vec = VEC_PF;
      4'(SRC_S1): win_vec = VEC_S1;
      4'(SRC_WD): win_vec = VEC_WD;
      default:
        if (win_idx < 4'(SRC_S1))
          win_vec = VEC_X0 + VEC_STEP * {4'h0, win_idx - 4'h1};
        else
          win_vec = VEC_X0 + VEC_STEP * {4'h0, win_idx};
    endcase
  end

  // ----------------------------------------------------------------------
  // Nesting stack of active levels
  // ----------------------------------------------------------------------
  logic [2:0] stk [NEST_DEPTH];
  logic [2:0] next_stk [NEST_DEPTH];
  logic [2:0] depth, next_depth;
  logic [2:0] cur_lvl;
  logic       vreq, next_vreq;
  logic [7:0] vaddr, next_vaddr;

  // Strictly higher only: equal level never preempts
  always_comb
  begin
    cur_lvl = (depth == 3'h0) ? LEVEL_NONE : stk[0];
    take    = last_mem_cycle_i && win_any
            && (depth == 3'h0 || win_lvl > cur_lvl);
  end

  // Push on vector, pop on return; until then service holds
  always_comb
  begin
    next_stk   = stk;
    next_depth = depth;
    next_vreq  = take;
    next_vaddr = take ? win_vec : vaddr;
    if (take)
    begin
      for (int i = NEST_DEPTH - 1; i > 0; i--)
        next_stk[i] = stk[i-1];
      next_stk[0] = win_lvl;
      next_depth  = depth + 3'h1;
    end
    else if (return_from_service_instr_i && depth != 3'h0)
    begin
      for (int i = 0; i < NEST_DEPTH - 1; i++)
        next_stk[i] = stk[i+1];
      next_stk[NEST_DEPTH-1] = 3'h0;
      next_depth = depth - 3'h1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < NEST_DEPTH; i++)
        stk[i] <= 3'h0;
      depth <= 3'h0;
      vreq  <= 1'b0;
      vaddr <= 8'h00;
    end
    else
    begin
      stk   <= next_stk;
      depth <= next_depth;
      vreq  <= next_vreq;
      vaddr <= next_vaddr;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------------
  logic [7:0] wdc_q, power_ctrl_reg_q;
  logic [2:0] alvl_q;
  logic       insvc_q;

  always_ff @(posedge mclk_i)
  begin
    wdc_q   <= {1'b0, por_flag, supply_drop_irq_en_i, flag[SRC_PF],
                wdt_flag, 3'h0};
    power_ctrl_reg_q  <= {2'h0, osc_flag, 5'h00};
    alvl_q  <= (next_depth == 3'h0) ? 3'h0 : next_stk[0];
    insvc_q <= (next_depth != 3'h0);
  end

  assign vector_req_o        = vreq;
  assign vector_addr_o       = vaddr;
  assign flags_o             = flag;
  assign active_level_o      = alvl_q;
  assign in_service_o        = insvc_q;
  assign watchdog_ctrl_reg_o = wdc_q;
  assign power_ctrl_reg_o    = power_ctrl_reg_q;
  assign flash_cmd_reg_o     = fcmd;
  assign flash_cmd_strobe_o  = fstb;
endmodule : fic_core

// ==== common/fic_pkg.sv ====
package fic_pkg;
  // ----------------------------------------------------------------------
  // Source numbering in natural order
  // ----------------------------------------------------------------------
  localparam int NUM_SRC = 13;
  localparam int SRC_PF  = 0;
  localparam int SRC_X0  = 1;
  localparam int SRC_T0  = 2;
  localparam int SRC_X1  = 3;
  localparam int SRC_T1  = 4;
  localparam int SRC_S0  = 5;
  localparam int SRC_T2  = 6;
  localparam int SRC_S1  = 7;
  localparam int SRC_X2  = 8;
  localparam int SRC_X3  = 9;
  localparam int SRC_X4  = 10;
  localparam int SRC_X5  = 11;
  localparam int SRC_WD  = 12;

  // ----------------------------------------------------------------------
  // Levels, vectors, field positions
  // ----------------------------------------------------------------------
  localparam logic [2:0] LEVEL_PF   = 3'h4;
  localparam logic [2:0] LEVEL_NONE = 3'h7;
  localparam logic [7:0] VEC_PF     = 8'h33;
  localparam logic [7:0] VEC_X0     = 8'h03;
  localparam logic [7:0] VEC_STEP   = 8'h08;
  localparam logic [7:0] VEC_S1     = 8'h3B;
  localparam logic [7:0] VEC_WD     = 8'h63;
  localparam int GATE_BIT      = 7;
  localparam int POR_BIT       = 6;
  localparam int PF_EN_BIT     = 5;
  localparam int WDT_RST_BIT   = 3;
  localparam int OSC_RST_BIT   = 5;
  localparam logic [3:0] FLASH_CMD_RESET = 4'h0;
  localparam logic [1:0] TA_IDLE = 2'h0;
  localparam int NEST_DEPTH = 5;

  // ----------------------------------------------------------------------
  // Timed access key bytes; values arbitrary
  // ----------------------------------------------------------------------
  localparam logic [7:0] TA_KEY1 = 8'hAA;
  localparam logic [7:0] TA_KEY2 = 8'h55;
  localparam int TA_WINDOW_CYC = 3;

  typedef enum logic [1:0] {FIC_TA_IDLE, FIC_TA_HALF, FIC_TA_OPEN}
    fic_ta_type;
endpackage : fic_pkg

// ==== logic/fic_arbiter.sv ====
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Priority arbiter: highest level wins, ties to lowest source index
// --------------------------------------------------------------------------
module fic_arbiter
  import fic_pkg::*;
#(
  parameter int N = NUM_SRC
)(
  // Requests and levels
  input  wire logic [N-1:0]   req_i,
  input  wire logic [3*N-1:0] level_i,
  // Winner
  output logic               any_o,
  output logic [3:0]         idx_o,
  output logic [2:0]         level_o
);
  // Scan from last to first so the lowest natural index wins a tie
  always_comb
  begin
    any_o   = 1'b0;
    idx_o   = 4'h0;
    level_o = 3'h0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_i[i] && (!any_o || level_i[3*i +: 3] >= level_o))
      begin
        any_o   = 1'b1;
        idx_o   = 4'(i);
        level_o = level_i[3*i +: 3];
      end
    end
  end
endmodule : fic_arbiter

// ==== dv/fic_core_properties.sv ====
`timescale 1ns/1ps
// ------------------------------------
// Port checker for the interrupt core
// ------------------------------------
module fic_core_properties
(
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  // Watched inputs
  input wire logic        last_mem_cycle_i,
  input wire logic [7:0]  interrupt_enable_reg_i,
  input wire logic        supply_drop_irq_en_i,
  input wire logic        timer0_ovf_i,
  input wire logic        wdt_reset_event_i,
  input wire logic        flash_cmd_wr_i,
  input wire logic [3:0]  flash_cmd_data_i,
  // Watched outputs
  input wire logic        vector_req_o,
  input wire logic [7:0]  vector_addr_o,
  input wire logic [12:0] flags_o,
  input wire logic [2:0]  active_level_o,
  input wire logic        in_service_o,
  input wire logic [7:0]  watchdog_ctrl_reg_o,
  input wire logic [3:0]  flash_cmd_reg_o,
  input wire logic        flash_cmd_strobe_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Takes, levels and vectors
  chk_take_sample:
    assert property (vector_req_o |-> $past(last_mem_cycle_i))
    else $error("vector without sample cycle");
  chk_pf_vector:
    assert property (vector_req_o && active_level_o == 3'h4
      |-> vector_addr_o == 8'h33)
    else $error("level four off its vector");
  chk_gate_block:
    assert property (vector_req_o && vector_addr_o != 8'h33
      |-> $past(interrupt_enable_reg_i[7]))
    else $error("vector with gate closed");
  chk_pf_enable:
    assert property (vector_req_o && vector_addr_o == 8'h33
      |-> $past(supply_drop_irq_en_i) && active_level_o == 3'h4)
    else $error("power-fail vector wrong");
  chk_preempt_level:
    assert property (vector_req_o && $past(in_service_o)
      |-> active_level_o > $past(active_level_o))
    else $error("preempt by equal or lower level");
  chk_service_hold:
    assert property (vector_req_o |-> in_service_o)
    else $error("vector without service state");
  // Flags and side registers
  chk_timer0_clear:
    assert property (vector_req_o && vector_addr_o == 8'h0B |-> !flags_o[2])
    else $error("timer 0 flag kept on vector");
  chk_flag_capture:
    assert property (timer0_ovf_i && !last_mem_cycle_i |=> flags_o[2])
    else $error("timer 0 flag not set");
  chk_flash_accept:
    assert property (flash_cmd_strobe_o |-> $past(flash_cmd_wr_i)
      && flash_cmd_reg_o == $past(flash_cmd_data_i))
    else $error("flash strobe without write");
  chk_wdt_cause:
    assert property (wdt_reset_event_i |-> ##[1:2] watchdog_ctrl_reg_o[3])
    else $error("watchdog cause flag missing");
endmodule : fic_core_properties

bind fic_core fic_core_properties i_fic_core_properties (.*);

// ==== dv/fic_cpu_model.sv ====
`timescale 1ns/1ps
// ------------------------------------
// CPU sequencer model
// ------------------------------------
module fic_cpu_model
#(
  parameter int INSTR_CYC = 4
)(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Return request from the bench
  input  wire logic ret_req_i,
  // Sequencer outputs
  output logic      last_mem_cycle_o,
  output logic      return_o
);
  logic [3:0] cnt, next_cnt;
  logic       pend, next_pend, next_last, next_ret;

  // Return lands after a sample cycle, so it never meets a take
  always_comb
  begin
    next_last = (cnt == 4'(INSTR_CYC - 1));
    next_cnt  = next_last ? 4'h0 : cnt + 4'h1;
    next_ret  = pend && last_mem_cycle_o;
    next_pend = (pend && !next_ret) || ret_req_i;
  end

  // Sequencer state
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cnt              <= 4'h0;
      pend             <= 1'b0;
      last_mem_cycle_o <= 1'b0;
      return_o         <= 1'b0;
    end
    else
    begin
      cnt              <= next_cnt;
      pend             <= next_pend;
      last_mem_cycle_o <= next_last;
      return_o         <= next_ret;
    end
  end
endmodule : fic_cpu_model

// ==== dv/tb_fic_core.sv ====
`timescale 1ns/1ps
// ------------------------------------
// Bench for the interrupt core
// ------------------------------------
module tb_fic_core;
  // Inputs driven by the bench are two-state, so all start at zero
  bit         mclk_i, sys_rst_i, por_event_i, wdt_reset_event_i;
  bit         osc_fail_event_i, sw_clr_por_i, sw_clr_wdt_rst_i;
  bit         sw_clr_osc_rst_i, ta_write_i, flash_cmd_wr_i, ret_req;
  bit         supply_drop_irq_en_i, supply_low_i, timer0_ovf_i;
  bit         timer1_ovf_i, timer2_overflow_flag_i, watchdog_irq_flag_i;
  bit         timer2_capture_edge_flag_i;
  bit  [7:0]  ta_data_i, interrupt_enable_reg_i;
  bit  [6:0]  prio_low_bits_reg_i, prio_high_bits_reg_i;
  bit  [4:0]  ext_irq_enable_reg_i, ext_prio_low_bits_reg_i;
  bit  [4:0]  ext_prio_high_bits_reg_i;
  bit  [3:0]  flash_cmd_data_i;
  bit  [1:0]  pin_trigger_mode_bit_i, serial0_flags_i, serial1_flags_i;
  bit  [5:0]  ext_pin_i;
  bit  [12:0] sw_flag_clr_i, sw_flag_set_i;
  logic       last_mem_cycle_i, return_from_service_instr_i;
  logic       vector_req_o, in_service_o, flash_cmd_strobe_o;
  logic [7:0] vector_addr_o, watchdog_ctrl_reg_o, power_ctrl_reg_o;
  logic [12:0] flags_o;
  logic [3:0] flash_cmd_reg_o;
  logic [2:0] active_level_o;
  int         bad_count, compares, i;

  fic_core i_fic_core (.*);

  fic_cpu_model #(.INSTR_CYC(4)) i_fic_cpu_model (
    .mclk_i           (mclk_i),
    .sys_rst_i        (sys_rst_i),
    .ret_req_i        (ret_req),
    .last_mem_cycle_o (last_mem_cycle_i),
    .return_o         (return_from_service_instr_i)
  );

  // Clock
  initial
  begin
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk_i);
  endtask : step

  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // Waits for a vector; level 7 means none may come in the window
  task automatic take(input logic [7:0] addr, input logic [2:0] lvl);
    int k;
    step();
    for (k = 0; k < 24 && vector_req_o !== 1'b1; k++)
      step();
    check(vector_req_o, lvl != 3'h7);
    if (lvl != 3'h7 && vector_req_o !== 1'b1)
      conclude();
    else if (lvl != 3'h7)
    begin
      check(vector_addr_o, addr);
      check(active_level_o, lvl);
    end
  endtask : take

  task automatic clr(input logic [12:0] m);
    step();
    sw_flag_clr_i <= m;
    step();
    sw_flag_clr_i <= '0;
  endtask : clr

  task automatic set(input logic [12:0] m);
    step();
    sw_flag_set_i <= m;
    step();
    sw_flag_set_i <= '0;
  endtask : set

  // Return waits on the sequencer, bounded
  task automatic ret();
    int k;
    step();
    ret_req <= 1'b1;
    step();
    ret_req <= 1'b0;
    for (k = 0; k < 24 && return_from_service_instr_i !== 1'b1; k++)
      step();
    if (k == 24)
    begin
      check(return_from_service_instr_i, 1'b1);
      conclude();
    end
    step(2);
  endtask : ret

  // Main sequence
  initial
  begin
    sys_rst_i = 1'b1;
    ext_pin_i = 6'h2B;
    step(5);
    sys_rst_i <= 1'b0;
    step();
    {por_event_i, wdt_reset_event_i, osc_fail_event_i} <= 3'h7;
    step();
    {por_event_i, wdt_reset_event_i, osc_fail_event_i} <= 3'h0;
    step(3);
    check({watchdog_ctrl_reg_o[6], watchdog_ctrl_reg_o[3],
           power_ctrl_reg_o[5]}, 3'h7);
    {sw_clr_por_i, sw_clr_wdt_rst_i, sw_clr_osc_rst_i} <= 3'h7;
    step();
    {sw_clr_por_i, sw_clr_wdt_rst_i, sw_clr_osc_rst_i} <= 3'h0;
    step(3);
    check({watchdog_ctrl_reg_o[6], watchdog_ctrl_reg_o[3],
           power_ctrl_reg_o[5]}, 3'h0);
    // Keyed flash write, then one without keys
    ta_write_i <= 1'b1;
    ta_data_i <= 8'hAA;
    step();
    ta_data_i <= 8'h55;
    step();
    ta_write_i <= 1'b0;
    flash_cmd_wr_i <= 1'b1;
    flash_cmd_data_i <= 4'hA;
    step();
    flash_cmd_wr_i <= 1'b0;
    step();
    check({flash_cmd_strobe_o, flash_cmd_reg_o}, 5'h1A);
    flash_cmd_wr_i <= 1'b1;
    flash_cmd_data_i <= 4'h5;
    step();
    flash_cmd_wr_i <= 1'b0;
    step();
    check({flash_cmd_strobe_o, flash_cmd_reg_o}, 5'h0A);
    // Pin 0 level, pin 1 edge, all enables off
    pin_trigger_mode_bit_i <= 2'h2;
    step(3);
    ext_pin_i <= 6'h14;
    {timer1_ovf_i, watchdog_irq_flag_i} <= 2'h3;
    timer2_capture_edge_flag_i <= 1'b1;
    step();
    {timer1_ovf_i, watchdog_irq_flag_i} <= 2'h0;
    step(3);
    check(flags_o, 13'h1F5A);
    ext_pin_i <= 6'h2B;
    timer2_capture_edge_flag_i <= 1'b0;
    step(3);
    check(flags_o, 13'h1F18);
    clr(13'h1FFF);
    step();
    check(flags_o, 13'h0);
    pin_trigger_mode_bit_i <= 2'h3;
    // Timer 0 through enable then gate
    step();
    timer0_ovf_i <= 1'b1;
    step();
    timer0_ovf_i <= 1'b0;
    take(8'h00, 3'h7);
    check(flags_o[2], 1'b1);
    interrupt_enable_reg_i <= 8'h02;
    take(8'h00, 3'h7);
    interrupt_enable_reg_i <= 8'h82;
    take(8'h0B, 3'h0);
    check(flags_o[2], 1'b0);
    ret();
    check(in_service_o, 1'b0);
    // Every programmable source in turn
    interrupt_enable_reg_i <= 8'hFF;
    ext_irq_enable_reg_i <= 5'h1F;
    for (i = 1; i < 13; i++)
    begin
      serial0_flags_i <= {1'b0, i == 5};
      timer2_overflow_flag_i <= (i == 6);
      serial1_flags_i <= {i == 7, 1'b0};
      set(13'h1 << i);
      take(8'(i > 6 ? 3 + 8 * i : 8 * i - 5), 3'h0);
      check(flags_o[i], i > 4);
      {serial0_flags_i, timer2_overflow_flag_i, serial1_flags_i} <= '0;
      clr(13'h1 << i);
      ret();
    end
    // Levels, ties and nesting
    prio_low_bits_reg_i <= 7'h06;
    ext_prio_high_bits_reg_i <= 5'h07;
    ext_prio_low_bits_reg_i <= 5'h04;
    set(13'h10C);
    take(8'h43, 3'h2);
    clr(13'h100);
    set(13'h200);
    take(8'h00, 3'h7);
    set(13'h400);
    take(8'h53, 3'h3);
    clr(13'h400);
    interrupt_enable_reg_i <= 8'h7F;
    supply_drop_irq_en_i <= 1'b1;
    supply_low_i <= 1'b1;
    take(8'h33, 3'h4);
    check(watchdog_ctrl_reg_o[5:4], 2'h3);
    supply_low_i <= 1'b0;
    clr(13'h1);
    repeat (3) ret();
    check(in_service_o, 1'b0);
    interrupt_enable_reg_i <= 8'hFF;
    take(8'h4B, 3'h2);
    clr(13'h200);
    ret();
    take(8'h0B, 3'h1);
    ret();
    take(8'h13, 3'h1);
    ret();
    conclude();
  end
endmodule : tb_fic_core
